//--- rtl/dsm_regs.vh
// register indices, reset values and classification limits of the diagnostic status mapper
`ifndef DSM_REGS_VH
`define DSM_REGS_VH

// ==========================================================================
// resource-block parameter indices (4-bit parameter address)
`define DSM_REG_MAP_BASE      4'h0
`define DSM_REG_PRI_BASE      4'h4
`define DSM_REG_DETECT_EN     4'h8
`define DSM_REG_SUPPRESS      4'h9
`define DSM_REG_MODE          4'hA
`define DSM_REG_FEATURE       4'hB
`define DSM_REG_ACTIVE        4'hC

// ==========================================================================
// map reset values, one per status signal, then write masks and the priority reset value
`define DSM_FAIL_MAP_RST      32'hF0000000
`define DSM_CHECK_MAP_RST     32'h0F000000
`define DSM_OFFSPEC_MAP_RST   32'h00F00000
`define DSM_MAINT_MAP_RST     32'h000F0000
`define DSM_MAP_WRITE_MASK    32'hFFFFFFFE
`define DSM_SLOT_MASK         16'hFFFE
`define DSM_PRI_RST           4'h0

// ==========================================================================
// map bit of the top range pair, slot value for "no individual slot"
`define DSM_RANGE_MSB         5'h1F
`define DSM_SLOT_NONE         4'h0

// ==========================================================================
// allocation range limits of the diagnostic number
`define DSM_SENSOR_LAST       10'h0C7
`define DSM_ELEC_LAST         10'h18F
`define DSM_CONFIG_LAST       10'h2BC
`define DSM_PROC_FIRST        10'h320
`define DSM_PROC_LAST         10'h3E7
`define DSM_RANGE_SENSOR      2'h0
`define DSM_RANGE_ELEC        2'h1
`define DSM_RANGE_CONFIG      2'h2
`define DSM_RANGE_PROC        2'h3

// ==========================================================================
// priority thresholds
`define DSM_PRI_DISPLAY_MIN   4'h1
`define DSM_PRI_SEND_MIN      4'h2

// ==========================================================================
// mode and feature bit positions
`define DSM_MODE_OOS_BIT      0
`define DSM_FEAT_MULTIBIT_BIT 0

`endif

//--- rtl/dsm_active_table.v
// table of active diagnostic events holding the status latched when each occurred
`timescale 1ns/1ns

module dsm_active_table #(
  parameter DEPTH  = 8,
  parameter NUM_W  = 10,
  parameter STAT_W = 4
) (
  // clock and reset
  input  wire              clk,
  input  wire              resetn,
  // event insert
  input  wire              ins_valid,
  input  wire [NUM_W-1:0]  ins_number,
  input  wire [STAT_W-1:0] ins_status,
  // event removal
  input  wire              del_valid,
  input  wire [NUM_W-1:0]  del_number,
  // aggregate state
  output reg  [STAT_W-1:0] active_status,
  output reg               table_full
);

  // ==========================================================================
  // storage
  reg  [DEPTH-1:0]  entry_valid;
  reg  [NUM_W-1:0]  entry_number [0:DEPTH-1];
  reg  [STAT_W-1:0] entry_status [0:DEPTH-1];
  wire [DEPTH-1:0]  ins_hit;
  wire [DEPTH-1:0]  del_hit;
  reg  [DEPTH-1:0]  first_free;
  reg               free_seen;
  reg  [STAT_W-1:0] next_active_status;
  wire              ins_take;
  integer           i;
  integer           j;
  integer           k;

  // ==========================================================================
  // per-entry number compare
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : gen_match
      assign ins_hit[g] = entry_valid[g] && (entry_number[g] == ins_number);
      assign del_hit[g] = entry_valid[g] && (entry_number[g] == del_number);
    end
  endgenerate

  // an event already held keeps its old status, so a remap never rewrites it
  assign ins_take = ins_valid && !(|ins_hit); // [RULE_13]

  // lowest free entry; a full table drops new events rather than evicting old
  always @* begin
    first_free = {DEPTH{1'b0}};
    free_seen  = 1'b0;
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (!entry_valid[i] && !free_seen) begin
        first_free[i] = 1'b1;
        free_seen     = 1'b1;
      end
    end
  end

  // or of the status latched by every active entry
  always @* begin
    next_active_status = {STAT_W{1'b0}};
    for (j = 0; j < DEPTH; j = j + 1) begin
      if (entry_valid[j]) begin
        next_active_status = next_active_status | entry_status[j];
      end
    end
  end

  // entry update; number and status only load on insert
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      entry_valid <= {DEPTH{1'b0}};
      for (k = 0; k < DEPTH; k = k + 1) begin
        entry_number[k] <= {NUM_W{1'b0}};
        entry_status[k] <= {STAT_W{1'b0}};
      end
    end else begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        if (del_valid && del_hit[k]) begin
          entry_valid[k] <= 1'b0;
        end else if (ins_take && first_free[k]) begin
          entry_valid[k]  <= 1'b1;
          entry_number[k] <= ins_number;
          entry_status[k] <= ins_status; // [RULE_13]
        end
      end
    end
  end

  // registered aggregate outputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_status <= {STAT_W{1'b0}};
      table_full    <= 1'b0;
    end else begin
      active_status <= next_active_status;
      table_full    <= &entry_valid;
    end
  end

endmodule // dsm_active_table

//--- rtl/dsm_status_mapper.v
// diagnostic status mapper: range maps, priorities, broadcast mask and event classification
//
// Operation
// RULE_01 - events carry one of three weightings; low splits into off-spec and maintenance
// RULE_02 - diagnostic number falls into sensor, electronics, configuration or process range
// RULE_03 - one range map per status signal, four maps in total
// RULE_04 - map bits 31..16 hold weighting-by-allocation pairs in fixed order
// RULE_05 - reset maps: failure 31-28, check 27-24, off-spec 23-20, maintenance 19-16
// RULE_06 - a map bit steers its whole range, never part of it
// RULE_07 - a range clear in all four maps sends no status signal
// RULE_08 - host keeps every range covered by at least one map bit
// RULE_09 - host switches to out-of-service before map edits, back afterwards
// RULE_10 - map bits 15..1 are configurable slots, cleared at reset
// RULE_11 - slot event recorded only when detect-enabled and its slot bit is mapped
// RULE_12 - slot event sent only when broadcast-enabled and its slot bit is mapped
// RULE_13 - remapping leaves active events alone; new status applies on next occurrence
// RULE_14 - priority 2..15 sends, 1 displays only, 0 ignores
// RULE_15 - each status signal has its own host-writable priority
// RULE_16 - suppression mask bit set stops sending but still displays
// RULE_17 - map configuration inactive at reset until multi-bit feature is selected
// RULE_18 - map bit 0 reserved: reads zero, ignores writes, selects nothing
// RULE_19 - classification is registered, presented one cycle after the event
`timescale 1ns/1ns
`include "dsm_regs.vh"

module dsm_status_mapper #(
  parameter TABLE_DEPTH = 8
) (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // resource-block parameter access from the host
  input  wire        param_wr,
  input  wire [3:0]  param_addr,
  input  wire [31:0] param_wdata,
  output reg  [31:0] param_rdata,
  // diagnostic event from the detection logic
  input  wire        event_valid,
  input  wire        event_raise,
  input  wire [9:0]  event_number,
  input  wire [1:0]  event_weight,
  input  wire [3:0]  event_slot,
  // classification result
  output reg         class_valid,
  output reg  [9:0]  class_number,
  output reg  [3:0]  class_status,
  output reg  [3:0]  class_display,
  output reg  [3:0]  class_transmit,
  // aggregate state
  output wire [3:0]  active_status,
  output wire        table_full
);

  // ==========================================================================
  // parameter storage; status index 0 fail, 1 check, 2 off-spec, 3 maintenance
  reg  [127:0] range_maps;          // [RULE_03]
  reg  [15:0]  priorities;          // [RULE_15]
  reg  [15:0]  detect_enable;
  reg  [31:0]  suppress_mask;
  reg          out_of_service_mode;
  reg          multibit_enable;
  reg  [31:0]  next_rdata;
  integer      i;

  // ==========================================================================
  // classification nets
  reg  [1:0]   range_idx;
  reg          range_ok;
  wire [4:0]   range_bit;
  wire         slot_used;
  wire [4:0]   sel_bit;
  wire         eligible;
  wire         suppressed;
  wire [127:0] eff_maps;
  wire [3:0]   map_we;
  wire [3:0]   pri_we;
  wire [3:0]   hit;
  wire [3:0]   show;
  wire [3:0]   send;
  wire         record;

  // ==========================================================================
  // per-status write decode, effective map and decision
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_status
      localparam integer MAP_IDX = `DSM_REG_MAP_BASE + g;
      localparam integer PRI_IDX = `DSM_REG_PRI_BASE + g;
      localparam [3:0] MAP_ADDR = MAP_IDX[3:0];
      localparam [3:0] PRI_ADDR = PRI_IDX[3:0];
      localparam [31:0] MAP_RST = (g == 0) ? `DSM_FAIL_MAP_RST :
                                  (g == 1) ? `DSM_CHECK_MAP_RST :
                                  (g == 2) ? `DSM_OFFSPEC_MAP_RST : `DSM_MAINT_MAP_RST;
      wire [3:0] pri;

      // map edits only land while the block is out of service
      assign map_we[g] = param_wr && out_of_service_mode && (param_addr == MAP_ADDR); // [RULE_09]
      assign pri_we[g] = param_wr && (param_addr == PRI_ADDR); // [RULE_15]

      // until the multi-bit option is chosen the factory maps stay in force
      assign eff_maps[g*32 +: 32] = multibit_enable ? range_maps[g*32 +: 32] : MAP_RST; // [RULE_17]

      // one map bit decides for the whole range; an unmapped range yields nothing
      assign hit[g]  = eligible && eff_maps[g*32 + sel_bit]; // [RULE_06] [RULE_07] [RULE_11]
      assign pri     = priorities[g*4 +: 4];
      assign show[g] = hit[g] && (pri >= `DSM_PRI_DISPLAY_MIN); // [RULE_14]
      assign send[g] = hit[g] && (pri >= `DSM_PRI_SEND_MIN) && !suppressed; // [RULE_14] [RULE_16] [RULE_12]
    end
  endgenerate

  // ==========================================================================
  // allocation range of the diagnostic number; 701..799 belongs to no range
  always @* begin
    range_ok  = 1'b1;
    range_idx = `DSM_RANGE_SENSOR;
    if (event_number <= `DSM_SENSOR_LAST) begin // [RULE_02]
      range_idx = `DSM_RANGE_SENSOR;
    end else if (event_number <= `DSM_ELEC_LAST) begin
      range_idx = `DSM_RANGE_ELEC;
    end else if (event_number <= `DSM_CONFIG_LAST) begin
      range_idx = `DSM_RANGE_CONFIG;
    end else if ((event_number >= `DSM_PROC_FIRST) && (event_number <= `DSM_PROC_LAST)) begin
      range_idx = `DSM_RANGE_PROC;
    end else begin
      range_ok = 1'b0;
    end
  end

  // weighting-major, allocation-minor, counting down from the top bit
  assign range_bit = `DSM_RANGE_MSB - {1'b0, event_weight, range_idx}; // [RULE_01] [RULE_04]

  // a slotted event uses its configurable bit instead of its range bit
  assign slot_used = (event_slot != `DSM_SLOT_NONE);
  assign sel_bit   = slot_used ? {1'b0, event_slot} : range_bit; // [RULE_10]

  // slotted events need detection enabled; bit 0 is never selectable
  assign eligible   = slot_used ? detect_enable[event_slot] : range_ok; // [RULE_11] [RULE_18]

  // negative selection: a set bit blocks sending of that range or slot only
  assign suppressed = suppress_mask[sel_bit]; // [RULE_16] [RULE_12]

  // a slotted event is only kept when some map carries its slot bit
  assign record = event_valid && event_raise && eligible && (!slot_used || (|hit)); // [RULE_11]

  // ==========================================================================
  // parameter registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      range_maps          <= {`DSM_MAINT_MAP_RST, `DSM_OFFSPEC_MAP_RST,
                              `DSM_CHECK_MAP_RST, `DSM_FAIL_MAP_RST}; // [RULE_05] [RULE_10]
      priorities          <= {4{`DSM_PRI_RST}}; // [RULE_14]
      detect_enable       <= 16'h0000;
      suppress_mask       <= 32'h00000000;
      out_of_service_mode <= 1'b0;
      multibit_enable     <= 1'b0; // [RULE_17]
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        // bit 0 is reserved and cannot be written
        if (map_we[i]) begin
          range_maps[i*32 +: 32] <= param_wdata & `DSM_MAP_WRITE_MASK; // [RULE_18]
        end
        if (pri_we[i]) begin
          priorities[i*4 +: 4] <= param_wdata[3:0]; // [RULE_15]
        end
      end
      if (param_wr && (param_addr == `DSM_REG_DETECT_EN)) begin
        detect_enable <= param_wdata[15:0] & `DSM_SLOT_MASK;
      end
      if (param_wr && (param_addr == `DSM_REG_SUPPRESS)) begin
        suppress_mask <= param_wdata & `DSM_MAP_WRITE_MASK;
      end
      if (param_wr && (param_addr == `DSM_REG_MODE)) begin
        out_of_service_mode <= param_wdata[`DSM_MODE_OOS_BIT];
      end
      if (param_wr && (param_addr == `DSM_REG_FEATURE)) begin
        multibit_enable <= param_wdata[`DSM_FEAT_MULTIBIT_BIT];
      end
    end
  end

  // ==========================================================================
  // read path; unused indices read zero
  always @* begin
    next_rdata = 32'h00000000;
    case (param_addr)
      4'h0, 4'h1, 4'h2, 4'h3: begin
        next_rdata = range_maps[param_addr[1:0]*32 +: 32]; // [RULE_18]
      end
      4'h4, 4'h5, 4'h6, 4'h7: begin
        next_rdata = {28'h0000000, priorities[param_addr[1:0]*4 +: 4]};
      end
      `DSM_REG_DETECT_EN: begin
        next_rdata = {16'h0000, detect_enable};
      end
      `DSM_REG_SUPPRESS: begin
        next_rdata = suppress_mask;
      end
      `DSM_REG_MODE: begin
        next_rdata = {31'h00000000, out_of_service_mode};
      end
      `DSM_REG_FEATURE: begin
        next_rdata = {31'h00000000, multibit_enable};
      end
      `DSM_REG_ACTIVE: begin
        next_rdata = {27'h0000000, table_full, active_status};
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // read data is registered so the host sees it one cycle after the address
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      param_rdata <= 32'h00000000;
    end else begin
      param_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // classification result, one cycle after the event
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      class_valid    <= 1'b0;
      class_number   <= 10'h000;
      class_status   <= 4'h0;
      class_display  <= 4'h0;
      class_transmit <= 4'h0;
    end else begin
      class_valid <= event_valid && event_raise; // [RULE_19]
      if (event_valid && event_raise) begin
        class_number   <= event_number;
        class_status   <= hit;
        class_display  <= show;
        class_transmit <= send; // [RULE_07]
      end
    end
  end

  // ==========================================================================
  // active event table; holds the status each event had when it occurred
  dsm_active_table #(
    .DEPTH  (TABLE_DEPTH),
    .NUM_W  (10),
    .STAT_W (4)
  ) u_table (
    .clk           (clk),
    .resetn        (resetn),
    .ins_valid     (record),
    .ins_number    (event_number),
    .ins_status    (hit),
    .del_valid     (event_valid && !event_raise),
    .del_number    (event_number),
    .active_status (active_status),
    .table_full    (table_full)
  );

endmodule // dsm_status_mapper

//--- bench/dsm_status_mapper_props.sv
// concurrent checks on the ports of the diagnostic status mapper
`timescale 1ns/1ns
module dsm_chk (
  // clock and reset
  input wire        clk,
  input wire        resetn,
  // host parameter bus
  input wire        param_wr,
  input wire [3:0]  param_addr,
  input wire [31:0] param_wdata,
  input wire [31:0] param_rdata,
  // event in
  input wire        event_valid,
  input wire        event_raise,
  input wire [9:0]  event_number,
  input wire [1:0]  event_weight,
  input wire [3:0]  event_slot,
  // result out
  input wire        class_valid,
  input wire [9:0]  class_number,
  input wire [3:0]  class_status,
  input wire [3:0]  class_display,
  input wire [3:0]  class_transmit,
  input wire [3:0]  active_status,
  input wire        table_full
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // result timing: removals never pulse the result strobe
  valid_lag_a: assert property (class_valid == $past(event_valid & event_raise))
    else $error("result strobe not one cycle after raise");
  number_cap_a: assert property (event_valid && event_raise |=> class_number == $past(event_number))
    else $error("result number differs from raised number");
  result_hold_a: assert property (!class_valid |-> $stable(class_status) && $stable(class_number))
    else $error("result moved without a raise");
  // ==========================================================================
  // decision consistency
  display_sub_a: assert property (class_valid |-> (class_display & ~class_status) == 4'h0)
    else $error("display without status");
  send_sub_a: assert property (class_valid |-> (class_transmit & ~class_display) == 4'h0)
    else $error("transmit without display");
  gap_silent_a: assert property (event_valid && event_raise && event_slot == 4'h0 && event_number > 10'h2BC
    && event_number < 10'h320 |=> class_status == 4'h0)
    else $error("status for number outside every range");
  // ==========================================================================
  // parameter read side
  map_bit0_a: assert property (param_addr < 4'h4 |=> param_rdata[0] == 1'b0)
    else $error("map bit 0 reads one");
  unmapped_zero_a: assert property (param_addr > 4'hC |=> param_rdata == 32'h0)
    else $error("unmapped index reads nonzero");
endmodule // dsm_chk

bind dsm_status_mapper dsm_chk u_chk (.clk(clk), .resetn(resetn), .param_wr(param_wr),
  .param_addr(param_addr), .param_wdata(param_wdata), .param_rdata(param_rdata),
  .event_valid(event_valid), .event_raise(event_raise), .event_number(event_number),
  .event_weight(event_weight), .event_slot(event_slot), .class_valid(class_valid),
  .class_number(class_number), .class_status(class_status), .class_display(class_display),
  .class_transmit(class_transmit), .active_status(active_status), .table_full(table_full));

//--- bench/dsm_host_model.sv
// host model: resource-block parameter writes, reads and framed map edits
`timescale 1ns/1ns
module dsm_host_model (
  // clock
  input  wire        clk,
  // parameter bus
  output reg         param_wr,
  output reg  [3:0]  param_addr,
  output reg  [31:0] param_wdata,
  input  wire [31:0] param_rdata
);
  initial begin
    param_wr    = 1'b0;
    param_addr  = 4'h0;
    param_wdata = 32'h0;
  end
  // strobe spans one rising edge; data scrambled after so stale values never match
  task write(input [3:0] a, input [31:0] d);
    begin
      @(negedge clk);
      param_wr    = 1'b1;
      param_addr  = a;
      param_wdata = d;
      @(negedge clk);
      param_wr    = 1'b0;
      param_wdata = ~d;
    end
  endtask
  // read data is registered, so it is taken one edge after the index
  task read(input [3:0] a, output [31:0] d);
    begin
      @(negedge clk);
      param_addr = a;
      @(negedge clk);
      d = param_rdata;
    end
  endtask
  // map edit framed by out-of-service and return to automatic
  task map_edit(input [1:0] i, input [31:0] d);
    begin
      write(4'hA, 32'h1);
      write({2'h0, i}, d); // range coverage is left to the caller
      write(4'hA, 32'h0);
    end
  endtask
endmodule // dsm_host_model

//--- bench/tb.sv
// self-checking bench of the diagnostic status mapper
`timescale 1ns/1ns
module tb;
  reg         clk;
  reg         resetn;
  wire        param_wr;
  wire [3:0]  param_addr;
  wire [31:0] param_wdata;
  wire [31:0] param_rdata;
  reg         event_valid;
  reg         event_raise;
  reg  [9:0]  event_number;
  reg  [1:0]  event_weight;
  reg  [3:0]  event_slot;
  wire        class_valid;
  wire [9:0]  class_number;
  wire [3:0]  class_status;
  wire [3:0]  class_display;
  wire [3:0]  class_transmit;
  wire [3:0]  active_status;
  wire        table_full;
  integer     n_errors, n_tests, i, j, k;
  reg  [31:0] bm [0:3];
  reg  [3:0]  bp [0:3];
  reg  [31:0] bdet, bsup, rd;
  reg         bmb;
  reg  [3:0]  es, e1;
  reg  [9:0]  n;
  localparam [99:0] EDGES = {10'h000, 10'h0C7, 10'h0C8, 10'h18F, 10'h190,
                             10'h2BC, 10'h2BD, 10'h31F, 10'h320, 10'h3E7};

  dsm_status_mapper #(.TABLE_DEPTH(2)) dut (.clk(clk), .resetn(resetn), .param_wr(param_wr),
    .param_addr(param_addr), .param_wdata(param_wdata), .param_rdata(param_rdata),
    .event_valid(event_valid), .event_raise(event_raise), .event_number(event_number),
    .event_weight(event_weight), .event_slot(event_slot), .class_valid(class_valid),
    .class_number(class_number), .class_status(class_status), .class_display(class_display),
    .class_transmit(class_transmit), .active_status(active_status), .table_full(table_full));
  dsm_host_model host (.clk(clk), .param_wr(param_wr), .param_addr(param_addr),
    .param_wdata(param_wdata), .param_rdata(param_rdata));

  // ==========================================================================
  // clock and watchdog
  initial clk = 1'b0;
  always #5 clk = ~clk;
  initial begin
    #(50000 * 10);
    n_errors = n_errors + 1;
    $display("watchdog expired");
    test_done;
  end

  // ==========================================================================
  // expectation helpers
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  // map bit steering an event: its slot, else the weighting-by-range pair
  function [4:0] f_bit(input [9:0] nn, input [1:0] w, input [3:0] s);
    reg [1:0] r;
    begin
      r = (nn <= 10'h0C7) ? 2'h0 : (nn <= 10'h18F) ? 2'h1 : (nn <= 10'h2BC) ? 2'h2 : 2'h3;
      f_bit = (s != 4'h0) ? {1'b0, s} : 5'h1F - {1'b0, w, 2'h0} - {3'h0, r};
    end
  endfunction
  function [3:0] f_status(input [9:0] nn, input [1:0] w, input [3:0] s);
    reg [31:0] m;
    integer    q;
    begin
      for (q = 0; q < 4; q = q + 1) begin
        m = bmb ? bm[q] : (32'hF0000000 >> (4 * q));
        f_status[q] = m[f_bit(nn, w, s)];
      end
      if ((s == 4'h0 && nn > 10'h2BC && nn < 10'h320) || (s != 4'h0 && !bdet[s]))
        f_status = 4'h0;
    end
  endfunction
  // one event; a raise has its result checked while the strobe stands
  task ev(input r, input [9:0] nn, input [1:0] w, input [3:0] s);
    reg [3:0] d, t;
    integer   q;
    begin
      es = f_status(nn, w, s);
      for (q = 0; q < 4; q = q + 1) begin
        d[q] = es[q] && bp[q] != 4'h0;
        t[q] = d[q] && bp[q] > 4'h1 && !bsup[f_bit(nn, w, s)];
      end
      @(negedge clk);
      event_valid  = 1'b1;
      event_raise  = r;
      event_number = nn;
      event_weight = w;
      event_slot   = s;
      @(negedge clk);
      event_valid  = 1'b0;
      event_number = ~nn;
      chk("valid", {31'h0, r}, {31'h0, class_valid});
      if (r) begin
        chk("number", {22'h0, nn}, {22'h0, class_number});
        chk("status", {28'h0, es}, {28'h0, class_status});
        chk("display", {28'h0, d}, {28'h0, class_display});
        chk("transmit", {28'h0, t}, {28'h0, class_transmit});
      end
    end
  endtask
  // raise then remove a random event so the active table stays empty
  task rand_ev;
    reg [3:0] s;
    begin
      s = ($urandom_range(2) == 0) ? $urandom_range(15) : 4'h0;
      n = $urandom_range(999);
      ev(1'b1, n, $urandom_range(3), s);
      ev(1'b0, n, 2'h0, 4'h0);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    n_errors = 0;
    n_tests = 0;
    resetn = 1'b0;
    event_valid = 1'b0;
    event_raise = 1'b0;
    event_number = 10'h000;
    event_weight = 2'h0;
    event_slot = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      bm[k] = 32'hF0000000 >> (4 * k);
      bp[k] = 4'h0;
    end
    bdet = 32'h0;
    bsup = 32'h0;
    bmb = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    i = $urandom(62);
    // reset values of every index, unmapped ones included
    for (i = 0; i < 16; i = i + 1) begin
      host.read(i[3:0], rd);
      chk("reset value", (i < 4) ? bm[i] : 32'h0, rd);
    end
    $display("test reset values done");
    // boundary priorities; map writes outside service mode and before the feature
    for (i = 0; i < 4; i = i + 1) begin
      rd = 32'h0F12 >> (4 * i);
      bp[i] = rd[3:0];
      host.write(i[3:0] + 4'h4, {28'h0, bp[i]});
    end
    host.write(4'h0, 32'h0);
    host.read(4'h0, rd);
    chk("map refused", bm[0], rd);
    host.map_edit(2'h1, 32'h0);
    bm[1] = 32'h0;
    for (i = 0; i < 30; i = i + 1)
      rand_ev;
    $display("test factory mapping done");
    // random maps, priorities, detect and suppress with the feature enabled
    bmb = 1'b1;
    host.write(4'hB, 32'h1);
    for (j = 0; j < 3; j = j + 1) begin
      for (k = 0; k < 4; k = k + 1) begin
        rd = $urandom;
        host.map_edit(k[1:0], rd);
        bm[k] = rd & 32'hFFFFFFFE;
        host.read(k[3:0], rd);
        chk("map readback", bm[k], rd);
        bp[k] = $urandom_range(15);
        host.write(k[3:0] + 4'h4, {28'h0, bp[k]});
      end
      bdet = $urandom & 32'h0000FFFE;
      bsup = $urandom & 32'hFFFFFFFE;
      host.write(4'h8, bdet);
      host.write(4'h9, bsup);
      for (i = 0; i < 60; i = i + 1)
        rand_ev;
      for (i = 0; i < 40; i = i + 1)
        ev(1'b1, EDGES[10 * (i % 10) +: 10], i / 10, 4'h0);
      for (i = 0; i < 10; i = i + 1)
        ev(1'b0, EDGES[10 * i +: 10], 2'h0, 4'h0);
    end
    $display("test random mapping done");
    // remapping leaves an active event alone, even when it occurs again, until it is removed and raised anew
    ev(1'b1, 10'h0C8, 2'h0, 4'h0);
    e1 = es;
    @(negedge clk);
    chk("active", {28'h0, e1}, {28'h0, active_status});
    for (k = 0; k < 4; k = k + 1) begin
      bm[k] = ~bm[k] & 32'hFFFFFFFE;
      host.map_edit(k[1:0], bm[k]);
    end
    ev(1'b1, 10'h0C8, 2'h0, 4'h0);
    @(negedge clk);
    chk("active kept", {28'h0, e1}, {28'h0, active_status});
    ev(1'b0, 10'h0C8, 2'h0, 4'h0);
    ev(1'b1, 10'h0C8, 2'h0, 4'h0);
    e1 = es;
    ev(1'b1, 10'h3E7, 2'h3, 4'h0);
    @(negedge clk);
    chk("active new", {28'h0, e1 | es}, {28'h0, active_status});
    chk("table full", 32'h1, {31'h0, table_full});
    // a detect-enabled slot whose bit no map carries is not recorded
    for (k = 0; k < 4; k = k + 1) begin
      bm[k] = bm[k] & 32'hFFFFFFFD;
      host.map_edit(k[1:0], bm[k]);
    end
    bdet = 32'h2;
    host.write(4'h8, bdet);
    ev(1'b0, 10'h3E7, 2'h3, 4'h0);
    ev(1'b1, 10'h005, 2'h0, 4'h1);
    @(negedge clk);
    chk("slot unrecorded", 32'h0, {31'h0, table_full});
    $display("test remap of active event done");
    test_done;
  end
endmodule // tb
